// ### lane_mon_pkg.sv
package lane_mon_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int LANES  = 8;
   localparam int LANE_W = 3;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CNT_W  = 8;

   // ------------------------------------------------------------
   // register addresses
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_FMT     = 12'h45a;
   localparam logic [ADDR_W-1:0] ADDR_SPARE1  = 12'h45b;
   localparam logic [ADDR_W-1:0] ADDR_SPARE2  = 12'h45c;
   localparam logic [ADDR_W-1:0] ADDR_CHKSUM  = 12'h45d;
   localparam logic [ADDR_W-1:0] ADDR_ERRSEL  = 12'h46b;
   localparam logic [ADDR_W-1:0] ADDR_DESKEW  = 12'h46c;
   localparam logic [ADDR_W-1:0] ADDR_DISPCTL = 12'h46d;
   localparam logic [ADDR_W-1:0] ADDR_NITCTL  = 12'h46e;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [DATA_W-1:0] RST_FMT    = 8'h80;
   localparam logic [DATA_W-1:0] RST_SPARE  = 8'h00;
   localparam logic [DATA_W-1:0] RST_CHKSUM = 8'h45;
   localparam logic [DATA_W-1:0] RST_DESKEW = 8'h0f;
   localparam logic [DATA_W-1:0] RD_ZERO    = 8'h00;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int DENS_BIT    = 7;
   localparam int CW_MSB      = 4;
   localparam int CW_LSB      = 0;
   localparam int SEL_LANE_HI = 6;
   localparam int SEL_LANE_LO = 4;
   localparam int SEL_TYPE_HI = 1;
   localparam int SEL_TYPE_LO = 0;
   localparam int CTL_IRQ_BIT = 7;
   localparam int CTL_OFF_BIT = 6;
   localparam int CTL_CLR_BIT = 5;
   localparam int CTL_LANE_HI = 2;
   localparam int CTL_LANE_LO = 0;

   // ------------------------------------------------------------
   // counter type decode
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CNT_DISP = 2'h0,
      CNT_NIT  = 2'h1,
      CNT_UCC  = 2'h2
   } cnt_type_t;

endpackage : lane_mon_pkg

// ### err_ctl_if.sv
`timescale 1ns/1ps
interface err_ctl_if #(
   parameter int LANES  = lane_mon_pkg::LANES,
   parameter int LANE_W = lane_mon_pkg::LANE_W,
   parameter int CNT_W  = lane_mon_pkg::CNT_W
);
   logic [LANE_W-1:0]           lane_pick;
   logic                        irq_clear;
   logic                        count_off;
   logic                        count_clear;
   logic [LANES-1:0]            err_hit;
   logic [CNT_W-1:0]            threshold;
   logic [LANES-1:0][CNT_W-1:0] count;
   logic [LANES-1:0]            flag;

   modport ctl (
      output lane_pick, irq_clear, count_off, count_clear,
      output err_hit, threshold,
      input  count, flag
   );
   modport bank (
      input  lane_pick, irq_clear, count_off, count_clear,
      input  err_hit, threshold,
      output count, flag
   );
endinterface : err_ctl_if

// ### err_count_bank.sv
`timescale 1ns/1ps
module err_count_bank #(
   parameter int LANES  = lane_mon_pkg::LANES,
   parameter int LANE_W = lane_mon_pkg::LANE_W,
   parameter int CNT_W  = lane_mon_pkg::CNT_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   err_ctl_if.bank  ctl
);

   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // ------------------------------------------------------------
   // one counter, disable and flag per lane
   // ------------------------------------------------------------
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [CNT_W-1:0] count_r;
      logic             off_r;
      logic             flag_r;
      logic             picked;
      logic             bump;

      assign picked = (ctl.lane_pick == LANE_W'(g));
      // saturate rather than wrap, so wrapping past threshold never re-fires a flag
      assign bump   = ctl.err_hit[g] && !off_r && (count_r != CNT_MAX);

      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            count_r <= '0;
         end else if (ctl.count_clear && picked) begin
            count_r <= '0;
         end else if (bump) begin
            count_r <= count_r + CNT_ONE;
         end
      end

      // disable stays until reset; no write re-enables
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            off_r <= 1'b0;
         end else if (ctl.count_off && picked) begin
            off_r <= 1'b1;
         end
      end

      // set on the count reaching threshold; set beats clear
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            flag_r <= 1'b0;
         end else if (bump && (count_r + CNT_ONE == ctl.threshold)) begin
            flag_r <= 1'b1;
         end else if (ctl.irq_clear && picked) begin
            flag_r <= 1'b0;
         end
      end

      assign ctl.count[g] = count_r;
      assign ctl.flag[g]  = flag_r;
   end

endmodule : err_count_bank

// ### lane_error_monitor.sv
`timescale 1ns/1ps
// Operation
// - checksum field shows lane zero checksum, method set by mode input
// - bits six to four choose the lane whose count reads back
// - type 00 disparity, 01 not in table, 10 unexpected control
// - deskew bit x includes lane x in deskew alignment
// - disparity flag x sets when lane x count reaches threshold
// - invalid code flag x sets when lane x count reaches threshold
// - write 1 to disparity bit seven clears picked lane flag
// - write 1 to disparity bit six stops picked lane counting
// - write 1 to disparity bit five zeroes picked lane counter
// - write 1 to invalid code bit seven clears picked lane flag
// - write 1 to invalid code bit six stops picked lane counting
// - write 1 to invalid code bit five zeroes picked lane counter
// - three-bit lane field picks which lane the actions hit
module lane_error_monitor #(
   parameter int LANES  = lane_mon_pkg::LANES,
   parameter int LANE_W = lane_mon_pkg::LANE_W,
   parameter int CNT_W  = lane_mon_pkg::CNT_W
) (
   input  wire logic                              mclk,
   input  wire logic                              rst_n,
   input  wire logic [lane_mon_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic                              reg_wr,
   input  wire logic [lane_mon_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                              reg_rd,
   output logic      [lane_mon_pkg::DATA_W-1:0]   reg_rdata,
   input  wire logic [CNT_W-1:0]                  err_threshold,
   input  wire logic [LANES-1:0]                  disp_err,
   input  wire logic [LANES-1:0]                  nit_err,
   input  wire logic [LANES-1:0]                  ucc_err,
   input  wire logic                              checksum_mode,
   input  wire logic                              checksum_load,
   input  wire logic [lane_mon_pkg::DATA_W-1:0]   param_octet_sum,
   input  wire logic [lane_mon_pkg::DATA_W-1:0]   param_field_sum,
   output logic                                   high_density_format,
   output logic      [lane_mon_pkg::CW_MSB:0]     control_words_per_frame,
   output logic      [LANES-1:0]                  deskew_enable_bits,
   output logic      [LANES-1:0]                  disparity_threshold_flags,
   output logic      [LANES-1:0]                  invalid_code_threshold_flags
);

   localparam int DW = lane_mon_pkg::DATA_W;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [DW-1:0]          fmt_r;
   logic [DW-1:0]          spare_byte_one_r;
   logic [DW-1:0]          spare_byte_two_r;
   logic [DW-1:0]          checksum_r;
   logic [LANE_W-1:0]      counter_lane_choice_r;
   logic [1:0]             counter_type_choice_r;
   logic [LANES-1:0]       deskew_r;
   logic [DW-1:0]          rdata_r;
   logic [DW-1:0]          rdata_nxt;
   logic [DW-1:0]          checksum_nxt;
   logic [CNT_W-1:0]       selected_error_count;

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   logic wr_fmt;
   logic wr_spare1;
   logic wr_spare2;
   logic wr_chksum;
   logic wr_errsel;
   logic wr_deskew;
   logic wr_dispctl;
   logic wr_nitctl;

   assign wr_fmt     = reg_wr && (reg_addr == lane_mon_pkg::ADDR_FMT);
   assign wr_spare1  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_SPARE1);
   assign wr_spare2  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_SPARE2);
   assign wr_chksum  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_CHKSUM);
   assign wr_errsel  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_ERRSEL);
   assign wr_deskew  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_DESKEW);
   assign wr_dispctl = reg_wr && (reg_addr == lane_mon_pkg::ADDR_DISPCTL);
   assign wr_nitctl  = reg_wr && (reg_addr == lane_mon_pkg::ADDR_NITCTL);

   // ------------------------------------------------------------
   // link parameter bytes
   // ------------------------------------------------------------
   // reserved bits 6:5 are never stored, so they read as zero;
   // legal values of the two fields are left to software
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fmt_r <= lane_mon_pkg::RST_FMT;
      end else if (wr_fmt) begin
         fmt_r <= '0;
         fmt_r[lane_mon_pkg::DENS_BIT] <=
            reg_wdata[lane_mon_pkg::DENS_BIT];
         fmt_r[lane_mon_pkg::CW_MSB:lane_mon_pkg::CW_LSB] <=
            reg_wdata[lane_mon_pkg::CW_MSB:lane_mon_pkg::CW_LSB];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         spare_byte_one_r <= lane_mon_pkg::RST_SPARE;
      end else if (wr_spare1) begin
         spare_byte_one_r <= reg_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         spare_byte_two_r <= lane_mon_pkg::RST_SPARE;
      end else if (wr_spare2) begin
         spare_byte_two_r <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // lane zero checksum
   // ------------------------------------------------------------
   // mode 0 sums whole octets, mode 1 sums the separate fields;
   // lower parameter bytes live elsewhere and arrive pre-summed
   always_comb begin
      if (checksum_mode) begin
         checksum_nxt = param_field_sum
                      + DW'(fmt_r[lane_mon_pkg::DENS_BIT])
                      + DW'(fmt_r[lane_mon_pkg::CW_MSB:
                                  lane_mon_pkg::CW_LSB]);
      end else begin
         checksum_nxt = param_octet_sum + fmt_r
                      + spare_byte_one_r + spare_byte_two_r;
      end
   end

   // a hardware load beats a software write in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         checksum_r <= lane_mon_pkg::RST_CHKSUM;
      end else if (checksum_load) begin
         checksum_r <= checksum_nxt;
      end else if (wr_chksum) begin
         checksum_r <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // counter readback select
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         counter_lane_choice_r <= '0;
         counter_type_choice_r <= '0;
      end else if (wr_errsel) begin
         counter_lane_choice_r <=
            reg_wdata[lane_mon_pkg::SEL_LANE_HI:
                      lane_mon_pkg::SEL_LANE_LO];
         counter_type_choice_r <=
            reg_wdata[lane_mon_pkg::SEL_TYPE_HI:
                      lane_mon_pkg::SEL_TYPE_LO];
      end
   end

   // ------------------------------------------------------------
   // deskew enables
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         deskew_r <= LANES'(lane_mon_pkg::RST_DESKEW);
      end else if (wr_deskew) begin
         deskew_r <= reg_wdata[LANES-1:0];
      end
   end

   // ------------------------------------------------------------
   // error counter banks
   // ------------------------------------------------------------
   err_ctl_if #(.LANES(LANES), .LANE_W(LANE_W), .CNT_W(CNT_W)) disp_if ();
   err_ctl_if #(.LANES(LANES), .LANE_W(LANE_W), .CNT_W(CNT_W)) nit_if ();
   err_ctl_if #(.LANES(LANES), .LANE_W(LANE_W), .CNT_W(CNT_W)) ucc_if ();

   // strobes act on the write edge itself, one per write
   assign disp_if.lane_pick   =
      reg_wdata[lane_mon_pkg::CTL_LANE_HI:
                lane_mon_pkg::CTL_LANE_LO];
   assign disp_if.irq_clear   =
      wr_dispctl && reg_wdata[lane_mon_pkg::CTL_IRQ_BIT];
   assign disp_if.count_off   =
      wr_dispctl && reg_wdata[lane_mon_pkg::CTL_OFF_BIT];
   assign disp_if.count_clear =
      wr_dispctl && reg_wdata[lane_mon_pkg::CTL_CLR_BIT];
   assign disp_if.err_hit     = disp_err;
   assign disp_if.threshold   = err_threshold;

   assign nit_if.lane_pick    =
      reg_wdata[lane_mon_pkg::CTL_LANE_HI:
                lane_mon_pkg::CTL_LANE_LO];
   assign nit_if.irq_clear    =
      wr_nitctl && reg_wdata[lane_mon_pkg::CTL_IRQ_BIT];
   assign nit_if.count_off    =
      wr_nitctl && reg_wdata[lane_mon_pkg::CTL_OFF_BIT];
   assign nit_if.count_clear  =
      wr_nitctl && reg_wdata[lane_mon_pkg::CTL_CLR_BIT];
   assign nit_if.err_hit      = nit_err;
   assign nit_if.threshold    = err_threshold;

   // unexpected-control controls sit outside this bank: never strobed
   assign ucc_if.lane_pick    = '0;
   assign ucc_if.irq_clear    = 1'b0;
   assign ucc_if.count_off    = 1'b0;
   assign ucc_if.count_clear  = 1'b0;
   assign ucc_if.err_hit      = ucc_err;
   assign ucc_if.threshold    = err_threshold;

   err_count_bank #(
      .LANES  (LANES),
      .LANE_W (LANE_W),
      .CNT_W  (CNT_W)
   ) u_disp_bank (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .ctl    (disp_if.bank)
   );

   err_count_bank #(
      .LANES  (LANES),
      .LANE_W (LANE_W),
      .CNT_W  (CNT_W)
   ) u_nit_bank (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .ctl    (nit_if.bank)
   );

   err_count_bank #(
      .LANES  (LANES),
      .LANE_W (LANE_W),
      .CNT_W  (CNT_W)
   ) u_ucc_bank (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .ctl    (ucc_if.bank)
   );

   // ------------------------------------------------------------
   // selected counter
   // ------------------------------------------------------------
   always_comb begin
      case (lane_mon_pkg::cnt_type_t'(counter_type_choice_r))
         lane_mon_pkg::CNT_DISP:
            selected_error_count =
               disp_if.count[counter_lane_choice_r];
         lane_mon_pkg::CNT_NIT:
            selected_error_count =
               nit_if.count[counter_lane_choice_r];
         lane_mon_pkg::CNT_UCC:
            selected_error_count =
               ucc_if.count[counter_lane_choice_r];
         default:
            selected_error_count = '0;
      endcase
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   // write-only fields never read back; reserved and unmapped are zero
   always_comb begin
      rdata_nxt = lane_mon_pkg::RD_ZERO;
      if (reg_addr == lane_mon_pkg::ADDR_FMT) begin
         rdata_nxt = fmt_r;
      end else if (reg_addr == lane_mon_pkg::ADDR_SPARE1) begin
         rdata_nxt = spare_byte_one_r;
      end else if (reg_addr == lane_mon_pkg::ADDR_SPARE2) begin
         rdata_nxt = spare_byte_two_r;
      end else if (reg_addr == lane_mon_pkg::ADDR_CHKSUM) begin
         rdata_nxt = checksum_r;
      end else if (reg_addr == lane_mon_pkg::ADDR_ERRSEL) begin
         rdata_nxt = DW'(selected_error_count);
      end else if (reg_addr == lane_mon_pkg::ADDR_DESKEW) begin
         rdata_nxt = DW'(deskew_r);
      end else if (reg_addr == lane_mon_pkg::ADDR_DISPCTL) begin
         rdata_nxt = DW'(disp_if.flag);
      end else if (reg_addr == lane_mon_pkg::ADDR_NITCTL) begin
         rdata_nxt = DW'(nit_if.flag);
      end
   end

   // data holds until the next read strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_r <= lane_mon_pkg::RD_ZERO;
      end else if (reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign reg_rdata                    = rdata_r;
   assign high_density_format          = fmt_r[lane_mon_pkg::DENS_BIT];
   assign control_words_per_frame      =
      fmt_r[lane_mon_pkg::CW_MSB:lane_mon_pkg::CW_LSB];
   assign deskew_enable_bits           = deskew_r;
   assign disparity_threshold_flags    = disp_if.flag;
   assign invalid_code_threshold_flags = nit_if.flag;

endmodule : lane_error_monitor

// ### link_tx_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far end: lane error events from the link transmitter
// ------------------------------------------------------------
// one pulse per lane per cycle; nothing is sent during reset
module link_tx_model (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   input  wire logic [7:0] mask,
   output logic      [7:0] disp_err,
   output logic      [7:0] nit_err,
   output logic      [7:0] ucc_err
);
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         disp_err <= 8'h00;
         nit_err  <= 8'h00;
         ucc_err  <= 8'h00;
      end else begin
         disp_err <= (go && kind == 2'h0) ? mask : 8'h00;
         nit_err  <= (go && kind == 2'h1) ? mask : 8'h00;
         ucc_err  <= (go && kind == 2'h2) ? mask : 8'h00;
      end
   end
endmodule : link_tx_model

// ### lane_mon_chk.sv
`timescale 1ns/1ps
module lane_mon_chk #(
   parameter int LANES  = lane_mon_pkg::LANES,
   parameter int LANE_W = lane_mon_pkg::LANE_W,
   parameter int CNT_W  = lane_mon_pkg::CNT_W
) (
   input wire logic                            mclk,
   input wire logic                            rst_n,
   input wire logic [lane_mon_pkg::ADDR_W-1:0] reg_addr,
   input wire logic                            reg_wr,
   input wire logic [lane_mon_pkg::DATA_W-1:0] reg_wdata,
   input wire logic                            reg_rd,
   input wire logic [lane_mon_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [CNT_W-1:0]                err_threshold,
   input wire logic [LANES-1:0]                disp_err,
   input wire logic [LANES-1:0]                nit_err,
   input wire logic [LANES-1:0]                deskew_enable_bits,
   input wire logic [LANES-1:0]                disparity_threshold_flags,
   input wire logic [LANES-1:0]                invalid_code_threshold_flags
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic wr_disp;
   logic wr_nit;
   logic wr_dsk;
   assign wr_disp = reg_wr && reg_addr == 12'h46d;
   assign wr_nit  = reg_wr && reg_addr == 12'h46e;
   assign wr_dsk  = reg_wr && reg_addr == 12'h46c;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   rdata_hold_a: assert property (
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
   spare_wr_a: assert property (
      reg_wr && reg_addr == 12'h45b ##1 reg_rd && !reg_wr
      && reg_addr == 12'h45b |=> reg_rdata == $past(reg_wdata, 2))
      else $error("spare byte lost");
   disp_rd_a: assert property (
      reg_rd && reg_addr == 12'h46d
      |=> reg_rdata == $past(disparity_threshold_flags))
      else $error("disparity flags misread");
   nit_rd_a: assert property (
      reg_rd && reg_addr == 12'h46e
      |=> reg_rdata == $past(invalid_code_threshold_flags))
      else $error("invalid code flags misread");
   deskew_wr_a: assert property (
      wr_dsk |=> deskew_enable_bits == $past(reg_wdata))
      else $error("deskew write lost");
   deskew_hold_a: assert property (
      !wr_dsk |=> $stable(deskew_enable_bits)) else $error("deskew moved");
   disp_clr_a: assert property (
      wr_disp && reg_wdata[7] && !disp_err[reg_wdata[2:0]]
      |=> !disparity_threshold_flags[$past(reg_wdata[2:0])])
      else $error("disparity flag not cleared");
   nit_clr_a: assert property (
      wr_nit && reg_wdata[7] && !nit_err[reg_wdata[2:0]]
      |=> !invalid_code_threshold_flags[$past(reg_wdata[2:0])])
      else $error("invalid code flag not cleared");
   disp_rise_a: assert property (
      (disparity_threshold_flags & ~$past(disparity_threshold_flags)
      & ~$past(disp_err)) == 8'h00) else $error("disparity flag no cause");
   nit_rise_a: assert property (
      (invalid_code_threshold_flags & ~$past(invalid_code_threshold_flags)
      & ~$past(nit_err)) == 8'h00) else $error("invalid flag no cause");
   cover property ($rose(|disparity_threshold_flags));
   cover property ($rose(|invalid_code_threshold_flags));
   cover property (wr_nit && reg_wdata[7]);
endmodule : lane_mon_chk

bind lane_error_monitor lane_mon_chk #(
   .LANES(LANES), .LANE_W(LANE_W), .CNT_W(CNT_W)
) i_chk (
   .mclk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
   .err_threshold, .disp_err, .nit_err, .deskew_enable_bits,
   .disparity_threshold_flags, .invalid_code_threshold_flags
);

// ### tb.sv
`timescale 1ns/1ps
module tb;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic [7:0]  thr = 8'h03;
   logic        ck_mode = 1'b0;
   logic        ck_load = 1'b0;
   logic [7:0]  osum = 8'h00;
   logic [7:0]  fsum = 8'h00;
   logic        go = 1'b0;
   logic [1:0]  kind = 2'h0;
   logic [7:0]  mask = 8'h00;
   logic [7:0]  disp_err, nit_err, ucc_err, deskew, dflag, nflag;
   logic        dens;
   logic [4:0]  cwpf;
   int          fail_count = 0;
   int          n_tests = 0;
   int          seed = 83972;
   int          r;
   int          cnt [3][8];
   bit          off [3][8];
   bit          flg [2][8];
   logic [11:0] ra [9] = '{12'h45a, 12'h45b, 12'h45c, 12'h45d, 12'h46b,
                           12'h46c, 12'h46d, 12'h46e, 12'h400};
   logic [7:0]  rv [9] = '{8'h80, 8'h00, 8'h00, 8'h45, 8'h00,
                           8'h0f, 8'h00, 8'h00, 8'h00};

   always #2.5 mclk = ~mclk;

   lane_error_monitor i_dut (
      .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .err_threshold(thr), .disp_err(disp_err), .nit_err(nit_err),
      .ucc_err(ucc_err), .checksum_mode(ck_mode), .checksum_load(ck_load),
      .param_octet_sum(osum), .param_field_sum(fsum),
      .high_density_format(dens), .control_words_per_frame(cwpf),
      .deskew_enable_bits(deskew), .disparity_threshold_flags(dflag),
      .invalid_code_threshold_flags(nflag));
   link_tx_model i_tx (
      .mclk(mclk), .rst_n(rst_n), .go(go), .kind(kind), .mask(mask),
      .disp_err(disp_err), .nit_err(nit_err), .ucc_err(ucc_err));

   // ------------------------------------------------------------
   // expectations and bus tasks
   // ------------------------------------------------------------
   function automatic logic [7:0] fl(int k);
      for (int l = 0; l < 8; l++) fl[l] = flg[k][l];
   endfunction : fl
   function automatic logic [7:0] ck_exp(bit m);
      // 0x45a holds 0x80, spares 0x12 and 0x34 at this point
      return m ? fsum + 8'h01 : osum + 8'h80 + 8'h12 + 8'h34;
   endfunction : ck_exp
   task automatic check(string nm, logic [7:0] e, logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : check
   task automatic wr(logic [11:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(logic [11:0] a, logic [7:0] e, string nm);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      check(nm, e, reg_rdata);
   endtask : rd
   task automatic hit(int k, logic [7:0] m);
      @(posedge mclk);
      kind <= 2'(k);
      mask <= m;
      go   <= 1'b1;
      @(posedge mclk);
      go   <= 1'b0;
      for (int l = 0; l < 8; l++)
         if (m[l] && !off[k][l] && cnt[k][l] < 255) begin
            cnt[k][l]++;
            if (k < 2 && cnt[k][l] == thr) flg[k][l] = 1;
         end
   endtask : hit
   task automatic ctl(int k, logic [2:0] b, logic [2:0] l);
      wr(k ? 12'h46e : 12'h46d, {b, 2'b00, l});
      if (b[2]) flg[k][l] = 0;
      if (b[1]) off[k][l] = 1;
      if (b[0]) cnt[k][l] = 0;
   endtask : ctl
   task automatic sel(int k, logic [2:0] l);
      wr(12'h46b, {1'b0, l, 2'b00, 2'(k)});
      rd(12'h46b, 8'(cnt[k][l]), "count");
   endtask : sel
   task automatic flags;
      rd(12'h46d, fl(0), "disp flags");
      rd(12'h46e, fl(1), "nit flags");
      check("disp port", fl(0), dflag);
      check("nit port", fl(1), nflag);
   endtask : flags
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 9; i++) rd(ra[i], rv[i], "reset");
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(12'h45b, r[7:0]);
         rd(12'h45b, r[7:0], "spare1");
         wr(12'h46c, r[15:8]);
         rd(12'h46c, r[15:8], "deskew");
         check("deskew port", r[15:8], deskew);
         wr(12'h45a, {r[23:21], 5'h00});
         rd(12'h45a, {r[23], 7'h00}, "format");
         check("dens port", {7'h00, r[23]}, {7'h00, dens});
         check("cwpf port", 8'h00, {3'h0, cwpf});
      end
      wr(12'h400, 8'hff);
      rd(12'h400, 8'h00, "unmapped");
      // read right behind the write, no idle cycle between
      wr(12'h45b, 8'h5a);
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      check("back to back", 8'h5a, reg_rdata);
      wr(12'h45a, 8'h80);
      wr(12'h45b, 8'h12);
      wr(12'h45c, 8'h34);
      for (int m = 0; m < 2; m++) begin
         r = $random(seed);
         @(posedge mclk);
         ck_mode <= m[0];
         osum    <= r[7:0];
         fsum    <= r[15:8];
         ck_load <= 1'b1;
         @(posedge mclk);
         ck_load <= 1'b0;
         rd(12'h45d, ck_exp(m[0]), "checksum");
      end
      $display("test registers done");
      repeat (3) hit(0, 8'h01);
      flags();
      ctl(0, 3'b100, 3'h0);
      ctl(1, 3'b011, 3'h2);
      hit(1, 8'h04);
      sel(1, 3'h2);
      repeat (260) hit(2, 8'h80);
      sel(2, 3'h7);
      wr(12'h46b, 8'h03);
      rd(12'h46b, 8'h00, "type 11");
      $display("test corners done");
      r = $random(seed);
      thr <= 8'h02 + 8'(r[1:0]);
      repeat (80) begin
         r = $random(seed);
         case (r[1:0])
            2'h0, 2'h1: hit(r[3:2] % 3, r[15:8]);
            2'h2: begin
               ctl(r[4], {r[7], r[6] & r[11] & r[12], r[5]}, r[10:8]);
               flags();
            end
            default: sel(r[3:2] % 3, r[6:4]);
         endcase
      end
      flags();
      $display("test random done");
      print_verdict();
   end

   initial begin
      repeat (30000) @(posedge mclk);
      fail_count++;
      print_verdict();
   end
endmodule : tb
